// >>> dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import tchp_pkg::*;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic stall = 1'b0;
	logic net_wr = 1'b0;
	logic [31:0] net_addr = 32'h0;
	logic [15:0] net_port = 16'h0;
	logic [7:0] rx_data, tx_data, ese, esr, sfx;
	logic rx_valid, rx_ready, tx_valid, tx_ready;
	logic cmd_valid, query, cmd_error, state_on;
	logic [31:0] addr_o;
	logic [15:0] port_o, val;
	logic [4:0] node;
	logic [3:0] np;
	logic [1:0] sp;
	int fail_count = 0;
	int n_tests = 0;
	int n_ev = 0;
	int n_err = 0;
	always #25 clock = ~clock;
	tchp_parser u_tchp_parser (.i_clock(clock), .i_arst_n(arst_n),
		.i_rx_data(rx_data), .i_rx_valid(rx_valid), .o_rx_ready(rx_ready),
		.o_tx_data(tx_data), .o_tx_valid(tx_valid), .i_tx_ready(tx_ready),
		.i_net_wr(net_wr), .i_net_addr(net_addr), .i_net_port(net_port),
		.o_net_addr(addr_o), .o_net_port(port_o), .o_cmd_valid(cmd_valid),
		.o_cmd_node(node), .o_cmd_query(query), .o_cmd_suffix(sfx),
		.o_cmd_value(val), .o_cmd_nparam(np), .o_cmd_special(sp),
		.o_cmd_error(cmd_error), .o_ese(ese), .o_esr(esr),
		.o_state_on(state_on));
	tchp_host u_tchp_host (.i_clock(clock), .i_rx_ready(rx_ready),
		.i_tx_data(tx_data), .i_tx_valid(tx_valid), .i_stall(stall),
		.o_rx_data(rx_data), .o_rx_valid(rx_valid), .o_tx_ready(tx_ready));
	always @(posedge clock) begin
		if (cmd_valid === 1'b1)
			n_ev <= n_ev + 1;
		if (cmd_error === 1'b1)
			n_err <= n_err + 1;
	end
	task automatic chk(input string w, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", w, e, g);
			fail_count++;
		end
	endtask
	// waits for the given number of pulses, bounded
	task automatic run(input string s, input int ev);
		int base;
		base = n_ev + n_err;
		@(posedge clock);
		u_tchp_host.send_line(s);
		for (int i = 0; i < 40 && n_ev + n_err < base + ev; i++)
			@(posedge clock);
		repeat (2) @(posedge clock);
	endtask
	task automatic chk_resp(input string s);
		for (int i = 0; i < 80 && u_tchp_host.resp.size() < s.len(); i++)
			@(posedge clock);
		chk("resp len", s.len(), u_tchp_host.resp.size());
		for (int i = 0; i < s.len() && i < u_tchp_host.resp.size(); i++)
			chk("resp byte", s[i], u_tchp_host.resp[i]);
		u_tchp_host.resp.delete();
	endtask
	task automatic t_reset();
		chk("addr", 32'h590a0b17, addr_o);
		chk("port", 16'h15b3, port_o);
		chk("ese", 8'h00, ese);
		net_addr <= 32'hc0a80102;
		net_port <= 16'h1f90;
		net_wr <= 1'b1;
		@(posedge clock);
		net_wr <= 1'b0;
		@(posedge clock);
		chk("new addr", 32'hc0a80102, addr_o);
		chk("new port", 16'h1f90, port_o);
		$display("done reset");
	endtask
	task automatic t_ese();
		run("*eSe\t253\n", 1);
		chk("ese", 8'hfd, ese);
		chk("node", NODE_ESE, node);
		$display("done ese");
	endtask
	task automatic t_error();
		int e0;
		e0 = n_err;
		run("FREQ:BOGUS 5\n", 1);
		chk("esr", 8'h20, esr);
		run("FREQU:STAR 1\n", 1);
		run("FREQ:STAT 1\n", 1);
		run("STEP 5\n", 1);
		chk("errors", 4, n_err - e0);
		run("FREQ:STAR? MAX\n", 1);
		chk("query", 1'b1, query);
		chk("special", SP_MAX, sp);
		chk("node", NODE_START, node);
		$display("done error");
	endtask
	task automatic t_path();
		int e0;
		e0 = n_err;
		run("SENS:FREQ:CW:STEP:INCR 25\n", 1);
		chk("node", NODE_STEP, node);
		chk("value", 16'h0019, val);
		chk("suffix", 8'h01, sfx);
		run("frequency:step 25\n", 1);
		chk("node", NODE_STEP, node);
		run("FREQ:STAR MIN;:OUTP:SQU:STAT3 1,2,3\n", 2);
		chk("node", NODE_STATE, node);
		chk("suffix", 8'h03, sfx);
		chk("nparam", 4'h3, np);
		run("FREQ:STAR DEF;STEP 5\n", 2);
		chk("node", NODE_STEP, node);
		chk("value", 16'h0005, val);
		chk("errors", 0, n_err - e0);
		$display("done path");
	endtask
	task automatic t_state();
		run("OUTP:SQU:STAT 1\n", 1);
		chk("state", 1'b1, state_on);
		run("output:squelch:state?\n", 0);
		chk_resp("1\n");
		run("OUTP:SQU:STAT? MIN\n", 0);
		chk("special", SP_MIN, sp);
		chk_resp("0\n");
		run("OutP:SQU:STAT 0\n", 1);
		chk("state", 1'b0, state_on);
		run("OUTP:SQU:STAT? MAX\n", 0);
		chk_resp("1\n");
		run("outp:squ:stat? def\n", 0);
		chk("special", SP_DEF, sp);
		chk_resp("0\n");
		run("outp:squ:stat?\n", 0);
		chk_resp("0\n");
		$display("done state");
	endtask
	// slow reader: answer stalls input until the fifo refuses
	task automatic t_fill();
		stall <= 1'b1;
		run("*ESR?\n", 0);
		fork
			u_tchp_host.send_line("*ESE 7\n");
			begin
				repeat (20) @(posedge clock);
				chk("rx_ready", 1'b0, rx_ready);
				stall <= 1'b0;
			end
		join
		chk_resp("032\n");
		repeat (10) @(posedge clock);
		chk("ese", 8'h07, ese);
		chk("esr", 8'h00, esr);
		$display("done fill");
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
		t_reset();
		t_ese();
		t_error();
		t_path();
		t_state();
		t_fill();
		conclude();
	end
	// whole run is well under two thousand cycles
	initial begin
		repeat (6000) @(posedge clock);
		fail_count++;
		conclude();
	end
endmodule
`default_nettype wire

// >>> dv/tchp_host.sv
`timescale 1ns/1ps
`default_nettype none
// remote controller: sends command lines, takes answer bytes
module tchp_host (
	input wire logic i_clock,
	input wire logic i_rx_ready,
	input wire logic [7:0] i_tx_data,
	input wire logic i_tx_valid,
	input wire logic i_stall,
	output logic [7:0] o_rx_data,
	output logic o_rx_valid,
	output logic o_tx_ready
);
	logic [7:0] resp[$];
	initial begin
		o_rx_data = 8'h00;
		o_rx_valid = 1'b0;
	end
	// stall lets the bench play a slow reader
	assign o_tx_ready = !i_stall;
	always @(posedge i_clock) begin
		if (i_tx_valid && o_tx_ready)
			resp.push_back(i_tx_data);
	end
	// line text always ends in LF; its path may be short or relative
	// no optional keyword stands next to a suffix digit
	task automatic send_line(input string s);
		for (int i = 0; i < s.len(); i++) begin
			o_rx_data <= s[i];
			o_rx_valid <= 1'b1;
			do @(posedge i_clock); while (i_rx_ready !== 1'b1);
		end
		o_rx_valid <= 1'b0;
		// idle bus never shows the last byte
		o_rx_data <= ~s[s.len()-1];
	endtask
endmodule
`default_nettype wire

// >>> rtl/tchp_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module tchp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic i_clock,
	input wire logic i_arst_n,
	input wire logic [WIDTH-1:0] i_in_data,
	input wire logic i_in_valid,
	output logic o_in_ready,
	output logic [WIDTH-1:0] o_out_data,
	output logic o_out_valid,
	input wire logic i_out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("fifo depth must be a power of two, two or more");
	end

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0] cnt_reg;
	logic [AW:0] cnt_next;
	logic ready_reg;
	logic push;
	logic pop;

	assign push = i_in_valid && ready_reg;
	assign pop = o_out_valid && i_out_ready;
	assign cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
	assign o_in_ready = ready_reg;
	assign o_out_valid = cnt_reg != '0;
	assign o_out_data = mem_reg[rd_reg];

	always_ff @(posedge i_clock) begin
		if (push) begin
			mem_reg[wr_reg] <= i_in_data;
		end
	end

	// ready is registered from the next count, so it drops in the cycle the fifo becomes full
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
			ready_reg <= 1'b1;
		end else begin
			wr_reg <= wr_reg + AW'(push);
			rd_reg <= rd_reg + AW'(pop);
			cnt_reg <= cnt_next;
			ready_reg <= cnt_next != FULL;
		end
	end
endmodule
`default_nettype wire

// >>> rtl/tchp_kw_match.sv
`timescale 1ns/1ps
`default_nettype none
module tchp_kw_match
	import tchp_pkg::*;
(
	input wire logic [KW_W-1:0] i_kw,
	input wire logic [3:0] i_len,
	input wire logic [NODE_W-1:0] i_cur,
	output logic o_hit,
	output logic [NODE_W-1:0] o_node,
	output logic [NODE_W-1:0] o_parent,
	output logic o_opt
);
	// short form is always the leading letters of the long form
	function automatic tchp_kw_type kw_entry(input logic [NODE_W-1:0] n);
		case (n)
			NODE_SENSE: kw_entry = '{"SENSE", 4'h5, 4'h4, NODE_ROOT, 1'b1};
			NODE_FREQ: kw_entry = '{"FREQUENCY", 4'h9, 4'h4, NODE_SENSE, 1'b0};
			NODE_CW: kw_entry = '{"CW", 4'h2, 4'h2, NODE_FREQ, 1'b1};
			NODE_STEP: kw_entry = '{"STEP", 4'h4, 4'h4, NODE_CW, 1'b0};
			NODE_INCR: kw_entry = '{"INCREMENT", 4'h9, 4'h4, NODE_STEP, 1'b1};
			NODE_START: kw_entry = '{"START", 4'h5, 4'h4, NODE_FREQ, 1'b0};
			NODE_OUTPUT: kw_entry = '{"OUTPUT", 4'h6, 4'h4, NODE_ROOT, 1'b0};
			NODE_SQUELCH: kw_entry = '{"SQUELCH", 4'h7, 4'h3, NODE_OUTPUT,
				1'b0};
			NODE_STATE: kw_entry = '{"STATE", 4'h5, 4'h4, NODE_SQUELCH, 1'b0};
			NODE_ESE: kw_entry = '{"ESE", 4'h3, 4'h3, NODE_STAR, 1'b0};
			NODE_ESR: kw_entry = '{"ESR", 4'h3, 4'h3, NODE_STAR, 1'b0};
			NODE_MIN: kw_entry = '{"MINIMUM", 4'h7, 4'h3, NODE_PARAM, 1'b0};
			NODE_MAX: kw_entry = '{"MAXIMUM", 4'h7, 4'h3, NODE_PARAM, 1'b0};
			NODE_DEF: kw_entry = '{"DEFAULT", 4'h7, 4'h3, NODE_PARAM, 1'b0};
			default: kw_entry = '0;
		endcase
	endfunction

	always_comb begin
		tchp_kw_type e;
		tchp_kw_type p;
		logic txt_ok;
		logic path_ok;
		e = '0;
		p = '0;
		txt_ok = 1'b0;
		path_ok = 1'b0;
		o_hit = 1'b0;
		o_node = NODE_ROOT;
		o_parent = NODE_ROOT;
		o_opt = 1'b0;
		for (int i = 1; i <= NODE_COUNT; i++) begin
			e = kw_entry(NODE_W'(i));
			p = kw_entry(e.par);
			txt_ok = (i_len == e.llen && i_kw == e.txt) || // RULE11
				(i_len == e.slen &&
				i_kw == (e.txt >> (8 * (e.llen - e.slen)))); // RULE12
			// an optional level between may be skipped
			path_ok = e.par == i_cur || (p.opt && p.par == i_cur); // RULE9
			if (!o_hit && i_len != 4'h0 && txt_ok && path_ok) begin // RULE8
				o_hit = 1'b1;
				o_node = NODE_W'(i);
				o_parent = e.par;
				o_opt = e.opt;
			end
		end
	end
endmodule
`default_nettype wire

// >>> rtl/tchp_parser.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE1: header keywords, whitespace, then parameters
// RULE2: trailing question mark makes a query
// RULE3: leading asterisk marks a common command
// RULE4: event status enable command loads enable register
// RULE5: event status query returns status register
// RULE6: one root keyword selects a command system
// RULE7: host sends full colon-separated keyword path; after a semicolon the parser also takes a path relative to the levels kept
// RULE8: keyword decoded by its level in path
// RULE9: optional keywords may be present or absent
// RULE10: host omits optional keyword when suffix used
// RULE11: only long or short form accepted
// RULE12: short form is the marked leading letters
// RULE13: letter case ignored when matching keywords
// RULE14: several parameters are separated by commas
// RULE15: MIN, MAX, DEF parameters give limits
// RULE16: numeric suffix selects instance, default one
// RULE17: network address and port reset defaults
// RULE18: new address or port applies at once
// RULE19: semicolon chains commands, colon returns root
// RULE20: boolean answers are digit 0 or 1
// RULE21: line feed ends line, path back root
// RULE22: unknown header discarded, command error flagged
module tchp_parser
	import tchp_pkg::*;
#(
	parameter int FIFO_DEPTH = 4,
	parameter int VAL_W = 16
) (
	input wire logic i_clock,
	input wire logic i_arst_n,
	input wire logic [7:0] i_rx_data,
	input wire logic i_rx_valid,
	output logic o_rx_ready,
	output logic [7:0] o_tx_data,
	output logic o_tx_valid,
	input wire logic i_tx_ready,
	input wire logic i_net_wr,
	input wire logic [31:0] i_net_addr,
	input wire logic [15:0] i_net_port,
	output logic [31:0] o_net_addr,
	output logic [15:0] o_net_port,
	output logic o_cmd_valid,
	output logic [NODE_W-1:0] o_cmd_node,
	output logic o_cmd_query,
	output logic [7:0] o_cmd_suffix,
	output logic [VAL_W-1:0] o_cmd_value,
	output logic [3:0] o_cmd_nparam,
	output logic [1:0] o_cmd_special,
	output logic o_cmd_error,
	output logic [7:0] o_ese,
	output logic [7:0] o_esr,
	output logic o_state_on
);
	if (VAL_W < 8) begin : g_bad_val
		$error("value width must hold at least one byte");
	end

	tchp_state_type state_reg;
	logic [NODE_W-1:0] cur_reg, node_reg;
	logic [KW_W-1:0] kw_reg;
	logic [3:0] len_reg, nparam_reg;
	logic [7:0] sfx_reg, hsfx_reg, ese_reg, esr_reg;
	logic sfx_seen_reg, pseen_reg, query_reg, bool_reg;
	logic [VAL_W-1:0] val_reg;
	logic [1:0] special_reg;
	logic [31:0] resp_reg, net_addr_reg;
	logic [2:0] resp_cnt_reg;
	logic [15:0] net_port_reg;
	logic [7:0] tx_data_reg;
	logic tx_valid_reg;
	logic cmd_valid_reg, cmd_query_reg, cmd_error_reg;
	logic [NODE_W-1:0] cmd_node_reg;
	logic [7:0] cmd_suffix_reg;
	logic [VAL_W-1:0] cmd_value_reg;
	logic [3:0] cmd_nparam_reg;
	logic [1:0] cmd_special_reg;

	logic [7:0] rx_byte, ch, digit;
	logic rx_valid, take, hdr, prm, is_end, is_alpha, legal;
	logic kw_end, hdr_bad, exec, resp_load, tx_adv, resp_done;
	logic m_hit, m_opt;
	logic [NODE_W-1:0] m_node, m_par, m_cur, canon, exec_node;
	logic [1:0] special_now, exec_special;
	logic [7:0] exec_sfx;

	tchp_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_clock(i_clock),
		.i_arst_n(i_arst_n),
		.i_in_data(i_rx_data),
		.i_in_valid(i_rx_valid),
		.o_in_ready(o_rx_ready),
		.o_out_data(rx_byte),
		.o_out_valid(rx_valid),
		.i_out_ready(take)
	);

	tchp_kw_match u_match (
		.i_kw(kw_reg),
		.i_len(len_reg),
		.i_cur(m_cur),
		.o_hit(m_hit),
		.o_node(m_node),
		.o_parent(m_par),
		.o_opt(m_opt)
	);

	// no byte is taken from the fifo while an answer is being sent; it stalls the source once full
	assign take = rx_valid && state_reg != ST_RESP;
	assign ch = upcase(rx_byte); // RULE13
	assign digit = rx_byte - CH_0;
	assign hdr = take && state_reg == ST_HDR;
	assign prm = take && state_reg == ST_PARAM;
	assign is_end = ch == CH_SEMI || ch == CH_LF; // RULE19 RULE21
	assign is_alpha = ch >= CH_A && ch <= CH_Z;
	assign legal = is_alpha || is_digit(ch) || is_ws(ch) || is_end ||
		ch == CH_COLON || ch == CH_QUERY || ch == CH_STAR;
	assign m_cur = state_reg == ST_PARAM ? NODE_PARAM : cur_reg;
	assign kw_end = hdr && len_reg != 4'h0 && (ch == CH_COLON ||
		ch == CH_QUERY || is_ws(ch) || is_end); // RULE1
	assign canon = m_opt ? m_par : m_node; // RULE9
	assign hdr_bad = hdr && ((kw_end && !m_hit) || !legal || // RULE22
		(is_alpha && (len_reg == 4'(KW_MAX) || sfx_seen_reg)) ||
		(is_digit(ch) && len_reg == 4'h0) ||
		(ch == CH_QUERY && len_reg == 4'h0) ||
		(ch == CH_STAR && (len_reg != 4'h0 || cur_reg == NODE_STAR)));
	assign exec = (kw_end && m_hit && is_end) || (prm && is_end);
	assign exec_node = prm ? node_reg : canon;
	assign exec_sfx = prm ? hsfx_reg :
		(sfx_seen_reg ? sfx_reg : SFX_DEFAULT); // RULE16
	assign exec_special = special_now != SP_NONE ? special_now :
		special_reg;
	assign resp_load = exec && query_reg &&
		(exec_node == NODE_ESR || exec_node == NODE_STATE);
	assign tx_adv = state_reg == ST_RESP && (!tx_valid_reg || i_tx_ready);
	assign resp_done = tx_adv && resp_cnt_reg == 3'h0;

	always_comb begin
		special_now = SP_NONE;
		if (prm && len_reg != 4'h0 && m_hit) begin // RULE15
			case (m_node)
				NODE_MIN: special_now = SP_MIN;
				NODE_MAX: special_now = SP_MAX;
				NODE_DEF: special_now = SP_DEF;
				default: special_now = SP_NONE;
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_reg <= ST_HDR;
		end else begin
			unique case (state_reg)
				ST_HDR: begin
					if (hdr_bad) begin
						state_reg <= is_end ? ST_HDR : ST_SKIP; // RULE22
					end else if (kw_end && !is_end && ch != CH_COLON) begin
						state_reg <= ST_PARAM; // RULE1 RULE2
					end
				end
				ST_PARAM: begin
					if (prm && is_end) begin
						state_reg <= resp_load ? ST_RESP : ST_HDR;
					end
				end
				ST_SKIP: begin
					if (take && is_end) begin
						state_reg <= ST_HDR;
					end
				end
				ST_RESP: begin
					if (resp_done) begin
						state_reg <= ST_HDR;
					end
				end
			endcase
		end
	end

	// path position; a semicolon keeps the levels shared so far, except after a common command or a bad header
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cur_reg <= NODE_ROOT;
		end else if (take && ch == CH_LF) begin
			cur_reg <= NODE_ROOT; // RULE21
		end else if (hdr_bad || (take && state_reg == ST_SKIP)) begin
			if (ch == CH_SEMI) begin
				cur_reg <= NODE_ROOT;
			end
		end else if (hdr && ch == CH_COLON) begin
			cur_reg <= len_reg == 4'h0 ? NODE_ROOT : m_node; // RULE19 RULE6
		end else if (hdr && ch == CH_STAR) begin
			cur_reg <= NODE_STAR; // RULE3
		end else if (take && ch == CH_SEMI && cur_reg == NODE_STAR) begin
			cur_reg <= NODE_ROOT;
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			kw_reg <= '0;
			len_reg <= 4'h0;
			sfx_reg <= 8'h00;
			sfx_seen_reg <= 1'b0;
		end else if (hdr_bad || kw_end || (take && state_reg == ST_SKIP) ||
			(prm && (is_end || is_ws(ch) || ch == CH_COMMA))) begin
			kw_reg <= '0;
			len_reg <= 4'h0;
			sfx_reg <= 8'h00;
			sfx_seen_reg <= 1'b0;
		end else if (take && is_alpha && len_reg != 4'(KW_MAX)) begin
			kw_reg <= {kw_reg[KW_W-9:0], ch}; // RULE13
			len_reg <= len_reg + 4'h1;
		end else if (hdr && is_digit(ch)) begin
			sfx_reg <= 8'(sfx_reg * DEC_BASE + digit); // RULE16
			sfx_seen_reg <= 1'b1;
		end
	end

	// per command: node, suffix, query, parameters
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			node_reg <= NODE_ROOT;
			hsfx_reg <= SFX_DEFAULT;
			query_reg <= 1'b0;
			val_reg <= '0;
			nparam_reg <= 4'h0;
			pseen_reg <= 1'b0;
			special_reg <= SP_NONE;
		end else if (exec || hdr_bad || state_reg == ST_SKIP) begin
			query_reg <= 1'b0;
			val_reg <= '0;
			nparam_reg <= 4'h0;
			pseen_reg <= 1'b0;
			special_reg <= SP_NONE;
		end else if (kw_end && m_hit && ch != CH_COLON) begin
			node_reg <= canon;
			hsfx_reg <= exec_sfx;
			query_reg <= ch == CH_QUERY; // RULE2
		end else if (prm) begin
			if (special_now != SP_NONE) begin
				special_reg <= special_now;
			end
			if (ch == CH_COMMA) begin
				nparam_reg <= nparam_reg + 4'h1; // RULE14
			end else if (!is_ws(ch)) begin
				pseen_reg <= 1'b1;
			end
			if (is_digit(ch) && nparam_reg == 4'h0) begin
				val_reg <= VAL_W'(val_reg * VAL_W'(DEC_BASE) + VAL_W'(digit));
			end
		end
	end

	// status bits: a new error wins over the clear by the status query
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ese_reg <= ESE_RST;
			esr_reg <= 8'h00;
			bool_reg <= 1'b0;
		end else begin
			esr_reg <= ((resp_load && exec_node == NODE_ESR) ? 8'h00 : // RULE5
				esr_reg) | (hdr_bad ? ESR_CME : 8'h00); // RULE22
			if (exec && !query_reg && exec_node == NODE_ESE && pseen_reg) begin
				ese_reg <= val_reg[7:0]; // RULE4
			end
			if (exec && !query_reg && exec_node == NODE_STATE && pseen_reg) begin
				bool_reg <= val_reg != '0;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			resp_reg <= '0;
			resp_cnt_reg <= 3'h0;
			tx_data_reg <= 8'h00;
			tx_valid_reg <= 1'b0;
		end else if (resp_load) begin
			if (exec_node == NODE_ESR) begin
				resp_reg <= {dec_digit(esr_reg, 2'h2), // RULE5
					dec_digit(esr_reg, 2'h1), dec_digit(esr_reg, 2'h0), CH_LF};
				resp_cnt_reg <= RESP_DEC_LEN;
			end else begin
				resp_reg <= {CH_0 + 8'(exec_special == SP_MAX || // RULE20
					(exec_special == SP_NONE && bool_reg)), CH_LF, 16'h0000};
				resp_cnt_reg <= RESP_BOOL_LEN;
			end
		end else if (tx_adv) begin
			tx_valid_reg <= resp_cnt_reg != 3'h0;
			tx_data_reg <= resp_reg[31:24];
			if (resp_cnt_reg != 3'h0) begin
				resp_reg <= {resp_reg[23:0], 8'h00};
				resp_cnt_reg <= resp_cnt_reg - 3'h1;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cmd_valid_reg <= 1'b0;
			cmd_error_reg <= 1'b0;
			cmd_node_reg <= NODE_ROOT;
			cmd_query_reg <= 1'b0;
			cmd_suffix_reg <= SFX_DEFAULT;
			cmd_value_reg <= '0;
			cmd_nparam_reg <= 4'h0;
			cmd_special_reg <= SP_NONE;
		end else begin
			cmd_valid_reg <= exec;
			cmd_error_reg <= hdr_bad; // RULE22
			if (exec) begin
				cmd_node_reg <= exec_node;
				cmd_query_reg <= query_reg;
				cmd_suffix_reg <= exec_sfx; // RULE16
				cmd_value_reg <= val_reg;
				cmd_nparam_reg <= nparam_reg + 4'(pseen_reg); // RULE14
				cmd_special_reg <= exec_special; // RULE15
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			net_addr_reg <= NET_ADDR_RST; // RULE17
			net_port_reg <= NET_PORT_RST;
		end else if (i_net_wr) begin
			net_addr_reg <= i_net_addr; // RULE18
			net_port_reg <= i_net_port;
		end
	end

	assign o_tx_data = tx_data_reg;
	assign o_tx_valid = tx_valid_reg;
	assign o_net_addr = net_addr_reg;
	assign o_net_port = net_port_reg;
	assign o_cmd_valid = cmd_valid_reg;
	assign o_cmd_node = cmd_node_reg;
	assign o_cmd_query = cmd_query_reg;
	assign o_cmd_suffix = cmd_suffix_reg;
	assign o_cmd_value = cmd_value_reg;
	assign o_cmd_nparam = cmd_nparam_reg;
	assign o_cmd_special = cmd_special_reg;
	assign o_cmd_error = cmd_error_reg;
	assign o_ese = ese_reg;
	assign o_esr = esr_reg;
	assign o_state_on = bool_reg;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_arst_n);

	property p_ws_param;
		kw_end && m_hit && is_ws(ch) |=> state_reg == ST_PARAM;
	endproperty
	a_ws_param: assert property (p_ws_param) // RULE1
		else $error("whitespace did not open parameters");

	property p_query;
		kw_end && m_hit && ch == CH_QUERY |=> query_reg;
	endproperty
	a_query: assert property (p_query) // RULE2
		else $error("question mark did not mark a query");

	property p_star;
		hdr && ch == CH_STAR && !hdr_bad |=> cur_reg == NODE_STAR;
	endproperty
	a_star: assert property (p_star) // RULE3
		else $error("asterisk did not start a common command");

	property p_ese;
		exec && !query_reg && exec_node == NODE_ESE && pseen_reg
			|=> o_ese == $past(val_reg[7:0]);
	endproperty
	a_ese: assert property (p_ese) // RULE4
		else $error("enable register not loaded");

	property p_esr;
		resp_load && exec_node == NODE_ESR
			|=> ##1 o_tx_valid && o_tx_data == dec_digit($past(o_esr, 2), 2'h2);
	endproperty
	a_esr: assert property (p_esr) // RULE5
		else $error("status query answer wrong");

	property p_lf_root;
		take && ch == CH_LF |=> cur_reg == NODE_ROOT;
	endproperty
	a_lf_root: assert property (p_lf_root) // RULE21
		else $error("line feed did not return to root");

	// header end without digits: suffix one, reported or held for later
	property p_sfx;
		kw_end && m_hit && ch != CH_COLON && !sfx_seen_reg
			|=> (o_cmd_valid ? o_cmd_suffix : hsfx_reg) == SFX_DEFAULT;
	endproperty
	a_sfx: assert property (p_sfx) // RULE16
		else $error("missing suffix not taken as one");

	property p_bad;
		hdr_bad |=> o_cmd_error && (o_esr & ESR_CME) != 8'h00 && !o_cmd_valid;
	endproperty
	a_bad: assert property (p_bad) // RULE22
		else $error("bad header not flagged");

	property p_net;
		i_net_wr |=> o_net_addr == $past(i_net_addr) &&
			o_net_port == $past(i_net_port);
	endproperty
	a_net: assert property (p_net) // RULE18
		else $error("network setting not applied at once");
endmodule
`default_nettype wire

// >>> rtl/tchp_pkg.sv
package tchp_pkg;
	localparam int KW_MAX = 12;
	localparam int KW_W = 8 * KW_MAX;
	localparam int NODE_W = 5;
	localparam int NODE_COUNT = 15;

	localparam logic [4:0] NODE_ROOT = 5'h00;
	localparam logic [4:0] NODE_SENSE = 5'h01;
	localparam logic [4:0] NODE_FREQ = 5'h02;
	localparam logic [4:0] NODE_CW = 5'h03;
	localparam logic [4:0] NODE_STEP = 5'h04;
	localparam logic [4:0] NODE_INCR = 5'h05;
	localparam logic [4:0] NODE_START = 5'h06;
	localparam logic [4:0] NODE_OUTPUT = 5'h07;
	localparam logic [4:0] NODE_SQUELCH = 5'h08;
	localparam logic [4:0] NODE_STATE = 5'h09;
	localparam logic [4:0] NODE_ESE = 5'h0a;
	localparam logic [4:0] NODE_ESR = 5'h0b;
	localparam logic [4:0] NODE_MIN = 5'h0d;
	localparam logic [4:0] NODE_MAX = 5'h0e;
	localparam logic [4:0] NODE_DEF = 5'h0f;
	localparam logic [4:0] NODE_PARAM = 5'h1e;
	localparam logic [4:0] NODE_STAR = 5'h1f;

	localparam logic [7:0] CH_HT = 8'h09;
	localparam logic [7:0] CH_LF = 8'h0a;
	localparam logic [7:0] CH_VT = 8'h0b;
	localparam logic [7:0] CH_SP = 8'h20;
	localparam logic [7:0] CH_STAR = 8'h2a;
	localparam logic [7:0] CH_COMMA = 8'h2c;
	localparam logic [7:0] CH_0 = 8'h30;
	localparam logic [7:0] CH_9 = 8'h39;
	localparam logic [7:0] CH_COLON = 8'h3a;
	localparam logic [7:0] CH_SEMI = 8'h3b;
	localparam logic [7:0] CH_QUERY = 8'h3f;
	localparam logic [7:0] CH_A = 8'h41;
	localparam logic [7:0] CH_Z = 8'h5a;
	localparam logic [7:0] CH_LA = 8'h61;
	localparam logic [7:0] CH_LZ = 8'h7a;
	localparam logic [7:0] CASE_BIT = 8'h20;
	localparam logic [7:0] DEC_BASE = 8'h0a;

	localparam logic [7:0] ESR_CME = 8'h20;
	localparam logic [7:0] ESE_RST = 8'h00;
	localparam logic [7:0] SFX_DEFAULT = 8'h01;
	localparam logic [31:0] NET_ADDR_RST = 32'h590a0b17;
	localparam logic [15:0] NET_PORT_RST = 16'h15b3;

	localparam logic [1:0] SP_NONE = 2'h0;
	localparam logic [1:0] SP_MIN = 2'h1;
	localparam logic [1:0] SP_MAX = 2'h2;
	localparam logic [1:0] SP_DEF = 2'h3;
	localparam logic [2:0] RESP_BOOL_LEN = 3'h2;
	localparam logic [2:0] RESP_DEC_LEN = 3'h4;

	typedef enum logic [1:0] {
		ST_HDR = 2'b00,
		ST_PARAM = 2'b01,
		ST_SKIP = 2'b10,
		ST_RESP = 2'b11
	} tchp_state_type;

	typedef struct packed {
		logic [KW_W-1:0] txt;
		logic [3:0] llen;
		logic [3:0] slen;
		logic [NODE_W-1:0] par;
		logic opt;
	} tchp_kw_type;

	function automatic logic is_ws(input logic [7:0] c);
		return (c <= CH_HT) || (c >= CH_VT && c <= CH_SP);
	endfunction

	function automatic logic is_digit(input logic [7:0] c);
		return c >= CH_0 && c <= CH_9;
	endfunction

	function automatic logic [7:0] upcase(input logic [7:0] c);
		return (c >= CH_LA && c <= CH_LZ) ? (c & ~CASE_BIT) : c;
	endfunction

	function automatic logic [7:0] dec_digit(input logic [7:0] v,
		input logic [1:0] pos);
		logic [7:0] q;
		q = (pos == 2'h2) ? v / (DEC_BASE * DEC_BASE) :
			(pos == 2'h1) ? (v / DEC_BASE) % DEC_BASE : v % DEC_BASE;
		return CH_0 + q;
	endfunction
endpackage
